//--- acr_pkg.sv
/*
  Constants, types and helper functions of the converter control and readout block.
  Assumes a 10 MHz aclk and an AXI4-Lite register bus with 32-bit data.
*/
// Operation
// - A convert_start_n fall starts a conversion that nothing restarts or aborts.
// - Power-scaled mode with convert_start_n low relaunches conversions by itself.
// - Self-running conversion exists only in power-scaled mode.
// - Power-scaled mode means power_scaled_select high and fastest_select low.
// - Power-scaled mode lowers operating current after each conversion phase.
// - Interface and reference stay active during low-power acquisition.
// - Data pins driven only while device_select_n and read_enable_n are low.
// - Serial output shares a pin of the parallel data bus.
// - serial_parallel_select low picks parallel, high picks serial readout.
// - Result readable after conversion, in acquisition, or during next conversion.
// - byte_order_select swaps the two result bytes on the data bus.
// - Serial readout sends 16 bits MSB first, one per shift_clock pulse.
// - output_coding_select picks straight binary or twos complement coding.
// - Reference and buffer power-down bits gate the reference path.
// - Out-of-range inputs saturate to the end codes, never wrap.
package acr_pkg;
  localparam int CLK_NS = 100;
  localparam int CONV_TIME_NS = 1000;
  localparam int ACQ_TIME_NS = 500;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_CYC = (ACQ_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  localparam int SER_BITS = 16;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h0c;
  localparam int CTRL_FASTEST = 0;
  localparam int CTRL_PSCALED = 1;
  localparam int CTRL_SERIAL = 2;
  localparam int CTRL_SWAP = 3;
  localparam int CTRL_BINARY = 4;
  localparam int CTRL_REFPD = 5;
  localparam int CTRL_BUFPD = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h10;
  localparam int STAT_DONE = 0;
  localparam int STAT_SER = 1;
  localparam int STAT_W = 2;
  localparam int STAT_BUSY = 8;
  localparam logic [STAT_W-1:0] MASK_RESET = 2'h0;
  localparam logic [15:0] CODE_MAX = 16'hffff;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_ACQ = 3'h4
  } acr_state_t;

  // Clamp a signed sample to the unsigned code range
  function automatic logic [15:0] acr_saturate(input logic signed [17:0] s);
    if (s > $signed({2'h0, CODE_MAX})) begin
      return CODE_MAX;
    end else if (s < $signed({2'h0, CODE_MIN})) begin
      return CODE_MIN;
    end
    return s[15:0];
  endfunction : acr_saturate

  // Straight binary or twos complement
  function automatic logic [15:0] acr_code(input logic [15:0] b, input logic binary);
    return binary ? b : (b ^ SIGN_FLIP);
  endfunction : acr_code
endpackage : acr_pkg

//--- acr_shift_if.sv
/*
  Carrier between the readout control and the serial shifter.
  Assumes both ends run on aclk.
*/
`timescale 1ns/1ns
interface acr_shift_if;
  logic load;
  logic [15:0] word;
  logic enable;
  logic shift_fall;
  logic bit_out;
  logic done;
  modport ctl (output load, output word, output enable, output shift_fall,
    input bit_out, input done);
  modport shf (input load, input word, input enable, input shift_fall,
    output bit_out, output done);
endinterface : acr_shift_if

//--- acr_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is an independent level from outside the aclk domain.
*/
`timescale 1ns/1ns
module acr_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] init,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= init;
      q <= init;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : acr_sync

//--- acr_shifter.sv
/*
  Serial result shifter, MSB first, advanced on each of the first 16 shift clock falls while enabled.
  Assumes shift_fall is already synchronised and edge detected.
*/
`timescale 1ns/1ns
module acr_shifter
  import acr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  acr_shift_if.shf port
);
  logic [15:0] sreg;
  logic [4:0] cnt;
  logic done_q;
  logic [15:0] next_sreg;
  logic [4:0] next_cnt;
  logic next_done;

  always_comb begin
    next_sreg = sreg;
    next_cnt = cnt;
    next_done = 1'b0;
    if (port.load) begin
      next_sreg = port.word;
      next_cnt = 5'h00;
    end else if (port.enable && port.shift_fall && cnt < 5'(SER_BITS)) begin
      next_sreg = {sreg[14:0], 1'b0};
      next_cnt = cnt + 5'h01;
      next_done = (cnt == 5'(SER_BITS - 1));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sreg <= 16'h0000;
      cnt <= 5'h10;
      done_q <= 1'b0;
    end else begin
      sreg <= next_sreg;
      cnt <= next_cnt;
      done_q <= next_done;
    end
  end

  // Bit holds from one fall to the next, across the rising edge
  assign port.bit_out = sreg[15];
  assign port.done = done_q;
endmodule : acr_shifter

//--- acr_top.sv
/*
  Conversion control, result readout over parallel or serial pins, and an
  AXI4-Lite register file with sticky status and interrupt.
  Assumes pins are asynchronous to aclk and analog_sample is on aclk.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module acr_top
  import acr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic convert_start_n,
  input wire logic power_down_input,
  input wire logic device_select_n,
  input wire logic read_enable_n,
  input wire logic shift_clock,
  input wire logic signed [17:0] analog_sample,
  output logic [15:0] data_out,
  output logic data_oe,
  output logic busy,
  output logic low_power,
  output logic reference_enable,
  output logic buffer_enable,
  output logic irq
);
  logic [4:0] pin_s;
  logic cnv_n_s, pd_s, cs_n_s, rd_n_s, sclk_s;
  logic cnv_n_d, sclk_d, sel_d;
  logic cnv_fall, sclk_fall, sel, sel_rise;
  acr_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [15:0] result, next_result;
  logic conv_end, next_busy;
  logic [CTRL_W-1:0] ctrl, next_ctrl;
  logic [STAT_W-1:0] stat, next_stat, mask, next_mask;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr, wr_addr;
  logic [31:0] w_data, next_w_data, wr_data;
  logic [3:0] w_strb, next_w_strb, wr_strb;
  logic next_bvalid, next_rvalid, wr_go, rd_go, stat_rd;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [15:0] next_dout;
  logic ps_mode, ser_mode;
  acr_shift_if shift ();

  acr_sync #(
    .W(5)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({convert_start_n, power_down_input, device_select_n, read_enable_n, shift_clock}),
    .init(5'h16),
    .q(pin_s)
  );
  assign {cnv_n_s, pd_s, cs_n_s, rd_n_s, sclk_s} = pin_s;

  acr_shifter u_shifter (
    .aclk(aclk),
    .aresetn(aresetn),
    .port(shift.shf)
  );

  // Edge detection on synchronised pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnv_n_d <= 1'b1;
      sclk_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      cnv_n_d <= cnv_n_s;
      sclk_d <= sclk_s;
      sel_d <= sel;
    end
  end
  assign cnv_fall = cnv_n_d && !cnv_n_s;
  assign sclk_fall = sclk_d && !sclk_s;
  assign sel = !(cs_n_s || rd_n_s);
  assign sel_rise = sel && !sel_d;

  assign ps_mode = ctrl[CTRL_PSCALED] && !ctrl[CTRL_FASTEST];
  assign ser_mode = ctrl[CTRL_SERIAL];

  // Conversion sequencing
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_result = result;
    conv_end = 1'b0;
    case (state)
      ST_IDLE: begin
        if (cnv_fall && !pd_s) begin
          next_state = ST_CONV;
          next_cnt = CNT_W'(CONV_CYC - 1);
        end else if (ps_mode && !cnv_n_s && !pd_s) begin
          next_state = ST_ACQ;
          next_cnt = CNT_W'(ACQ_CYC - 1);
        end
      end
      ST_CONV: begin
        // Start and power-down requests are ignored until the end
        if (cnt == '0) begin
          conv_end = 1'b1;
          next_result = acr_code(acr_saturate(analog_sample), ctrl[CTRL_BINARY]);
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      ST_ACQ: begin
        if (!ps_mode || cnv_n_s || pd_s) begin
          next_state = ST_IDLE;
        end else if (cnt == '0) begin
          next_state = ST_CONV;
          next_cnt = CNT_W'(CONV_CYC - 1);
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
    next_busy = (next_state == ST_CONV);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      result <= 16'h0000;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      result <= next_result;
      busy <= next_busy;
    end
  end

  // Serial readout on the top data pin
  assign shift.load = sel_rise || conv_end;
  assign shift.word = conv_end ? next_result : result;
  assign shift.enable = sel && ser_mode;
  assign shift.shift_fall = sclk_fall;

  // Data pins, registered
  always_comb begin
    if (ser_mode) begin
      next_dout = {shift.bit_out, 15'h0000};
    end else if (ctrl[CTRL_SWAP]) begin
      next_dout = {result[7:0], result[15:8]};
    end else begin
      next_dout = result;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= 16'h0000;
    end else begin
      data_out <= next_dout;
    end
  end
  assign data_oe = sel;

  assign low_power = ps_mode && !busy;
  assign reference_enable = !ctrl[CTRL_REFPD];
  assign buffer_enable = !ctrl[CTRL_BUFPD];
  assign irq = |(stat & mask);

  // AXI4-Lite slave
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;
  assign wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_go && (s_axi_araddr == ADDR_STATUS);

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_ctrl = ctrl;
    next_mask = mask;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      case (wr_addr)
        ADDR_CTRL: begin
          if (wr_strb[0]) begin
            next_ctrl = wr_data[CTRL_W-1:0];
          end
        end
        ADDR_MASK: begin
          if (wr_strb[0]) begin
            next_mask = wr_data[STAT_W-1:0];
          end
        end
        ADDR_STATUS, ADDR_RESULT: begin
          next_bresp = RESP_OKAY;
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    // Set wins over the clear by read
    next_stat = (stat & ~(stat_rd ? '1 : STAT_W'(0))) | {shift.done, conv_end};
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: next_rdata = {25'h0000000, ctrl};
        ADDR_STATUS: next_rdata = {23'h000000, busy, 6'h00, stat};
        ADDR_MASK: next_rdata = {30'h00000000, mask};
        ADDR_RESULT: next_rdata = {16'h0000, result};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
      stat <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      ctrl <= next_ctrl;
      mask <= next_mask;
      stat <= next_stat;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule : acr_top

//--- acr_assertions.sv
/*
  Port checker for acr_top.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module acr_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_down_input,
  input wire logic device_select_n,
  input wire logic read_enable_n,
  input wire logic data_oe,
  input wire logic busy,
  input wire logic low_power
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_conv;
    busy [*8] ##1 busy [*2];
  endsequence
  property p_conv;
    $rose(busy) |-> s_conv ##1 !busy;
  endproperty
  property p_pd;
    !busy && $past(power_down_input, 2) |=> !busy;
  endproperty
  property p_oe;
    data_oe == (!$past(device_select_n, 2) && !$past(read_enable_n, 2));
  endproperty
  property p_lowp;
    busy |-> !low_power;
  endproperty
  property p_b;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
  endproperty
  property p_bone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_conv: assert property (p_conv) else $error("busy length wrong");
  a_pd: assert property (p_pd) else $error("start while powered down");
  a_oe: assert property (p_oe) else $error("data enable wrong");
  a_lowp: assert property (p_lowp) else $error("low power during busy");
  a_b: assert property (p_b) else $error("no write response");
  a_bone: assert property (p_bone) else $error("write response repeated");
  a_r: assert property (p_r) else $error("no read data");
  a_rone: assert property (p_rone) else $error("read data repeated");
endmodule : acr_assertions
bind acr_top acr_assertions i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .power_down_input, .device_select_n,
  .read_enable_n, .data_oe, .busy, .low_power);

//--- acr_host_model.sv
/*
  Host reading results over the data pins, parallel or serial.
  Assumes bus shows the pins as seen by the host, released pins inverted.
*/
`timescale 1ns/1ns
module acr_host_model (
  input wire logic aclk,
  input wire logic [15:0] bus,
  output logic cs_n,
  output logic rd_n,
  output logic shift_clock
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    shift_clock = 1'b0;
  end
  task automatic sel(input logic c, input logic r);
    @(posedge aclk);
    cs_n <= c;
    rd_n <= r;
    repeat (6) @(posedge aclk);
  endtask : sel
  task automatic read_par(output logic [15:0] w);
    sel(1'b0, 1'b0);
    @(negedge aclk);
    w = bus;
    sel(1'b1, 1'b1);
  endtask : read_par
  // Sixteen pulses of 400 ns, one every 800 ns, clock idle low between frames
  task automatic read_ser(output logic [15:0] w);
    sel(1'b0, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      shift_clock <= 1'b1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      w[i] = bus[15];
      @(posedge aclk);
      shift_clock <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    sel(1'b1, 1'b1);
  endtask : read_ser
endmodule : acr_host_model

//--- tb.sv
/*
  Self-checking bench for acr_top.
  Assumes a 10 MHz aclk and the host model on the data pins.
*/
`timescale 1ns/1ns
module tb;
  import acr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic convert_start_n = 1'b1, power_down_input = 1'b0;
  logic device_select_n, read_enable_n, shift_clock, bin, busy_d = 1'b0, lp_seen = 1'b0;
  logic signed [17:0] analog_sample = 18'sh00000;
  logic signed [17:0] smp [3] = '{18'sh01234, 18'sh1ffff, 18'sh3fffb};
  logic [31:0] cfg [4] = '{32'h10, 32'h11, 32'h13, 32'h12};
  logic [15:0] data_out, host_bus, w, e;
  logic data_oe, busy, low_power, reference_enable, buffer_enable, irq;
  int n_mismatch = 0, checks = 0, n_rise = 0, dr;
  always #50 aclk = ~aclk;
  assign host_bus = data_oe ? data_out : ~data_out;
  acr_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .convert_start_n, .power_down_input, .device_select_n, .read_enable_n, .shift_clock,
    .analog_sample, .data_out, .data_oe, .busy, .low_power, .reference_enable,
    .buffer_enable, .irq);
  acr_host_model i_host (.aclk, .bus(host_bus), .cs_n(device_select_n),
    .rd_n(read_enable_n), .shift_clock);
  always @(negedge aclk) begin
    if (busy === 1'b1 && busy_d === 1'b0) n_rise++;
    busy_d = busy;
    if (low_power === 1'b1) lp_seen = 1'b1;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw, wd, a1, w1;
    aw = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && wd)) begin
      @(negedge aclk);
      a1 = s_axi_awready && !aw;
      w1 = s_axi_wready && !wd;
      @(posedge aclk);
      if (a1) s_axi_awvalid <= 1'b0;
      if (w1) s_axi_wvalid <= 1'b0;
      aw = aw | a1;
      wd = wd | w1;
    end
    do begin
      @(negedge aclk);
      a1 = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
    end while (a1 !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x,
    input logic [1:0] xr);
    logic g;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      g = s_axi_arready;
      @(posedge aclk);
    end while (g !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      g = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
    end while (g !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(n, d, x);
    chk(n, rs, xr);
  endtask : rc
  function automatic logic [15:0] code(input logic signed [17:0] s, input logic b);
    logic [15:0] c;
    c = (s > 18'sh0ffff) ? 16'hffff : ((s < 18'sh00000) ? 16'h0000 : s[15:0]);
    return b ? c : (c ^ 16'h8000);
  endfunction : code
  // One conversion, with a restart try and optional power-down inside it
  task automatic conv(input logic signed [17:0] s, input logic pd);
    int n;
    n = 0;
    @(posedge aclk);
    analog_sample <= s;
    convert_start_n <= 1'b0;
    do begin
      @(negedge aclk);
      n++;
    end while (busy !== 1'b1 && n < 20);
    chk("busy", busy, 1'b1);
    n = 1;
    while (n < 30) begin
      @(posedge aclk);
      convert_start_n <= (n != 5);
      power_down_input <= pd;
      @(negedge aclk);
      if (busy !== 1'b1) break;
      n++;
    end
    chk("conv len", n, CONV_CYC);
    @(posedge aclk);
    power_down_input <= 1'b0;
  endtask : conv
  task automatic hold(input logic [31:0] c, input logic pd, output int d);
    int m;
    wr(ADDR_CTRL, c, r);
    @(posedge aclk);
    power_down_input <= pd;
    repeat (6) @(posedge aclk);
    lp_seen = 1'b0;
    m = n_rise;
    convert_start_n <= 1'b0;
    repeat (64) @(posedge aclk);
    convert_start_n <= 1'b1;
    d = n_rise - m;
    repeat (20) @(posedge aclk);
    power_down_input <= 1'b0;
  endtask : hold
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rc("ctrl", ADDR_CTRL, 32'h10, RESP_OKAY);
    rc("mask", ADDR_MASK, 32'h0, RESP_OKAY);
    chk("refs", {reference_enable, buffer_enable}, 2'h3);
    rc("unmapped", 8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h1, r);
    chk("unmapped wr", r, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      bin = i < 3;
      wr(ADDR_CTRL, {27'h0, bin, 4'h0}, r);
      conv(smp[i % 3], i == 1);
      e = code(smp[i % 3], bin);
      rc("result", ADDR_RESULT, {16'h0, e}, RESP_OKAY);
      i_host.read_par(w);
      chk("parallel", w, e);
    end
    wr(ADDR_CTRL, 32'h08, r);
    i_host.read_par(w);
    chk("swap", w, {e[7:0], e[15:8]});
    for (int k = 0; k < 4; k++) begin
      i_host.sel(k[0], k[1]);
      @(negedge aclk);
      chk("oe", data_oe, k == 0);
    end
    rc("status", ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_MASK, 32'h2, r);
    wr(ADDR_CTRL, 32'h14, r);
    conv(18'sh0a5c3, 1'b0);
    @(negedge aclk);
    chk("irq masked", irq, 1'b0);
    rc("status done", ADDR_STATUS, 32'h1, RESP_OKAY);
    i_host.read_ser(w);
    chk("serial", w, 16'ha5c3);
    @(negedge aclk);
    chk("irq", irq, 1'b1);
    rc("status ser", ADDR_STATUS, 32'h2, RESP_OKAY);
    @(negedge aclk);
    chk("irq clear", irq, 1'b0);
    for (int k = 0; k < 4; k++) begin
      hold(cfg[k], 1'b0, dr);
      chk("rises", (k == 3) ? (dr >= 3) : dr, 1);
      chk("low power", lp_seen, k == 3);
    end
    hold(32'h10, 1'b1, dr);
    chk("pd rises", dr, 0);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_CTRL, 32'h10 | ((k > 0) << 5) | ((k == 2) << 6), r);
      chk("refs", {reference_enable, buffer_enable}, {k == 0, k != 2});
    end
    test_done();
  end
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end
endmodule : tb
